// ==== include/scs_consts.svh ====
// constants of the conversion sequencer: offsets, fields, reset values, timing
// assumes inclusion by bare name from design and bench files
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// ==========================================================================
// register map (byte addresses)
`define SCS_ADDR_CTRL      8'h00
`define SCS_ADDR_STATUS    8'h04
`define SCS_ADDR_RESULT    8'h08
`define SCS_ADDR_COUNT     8'h0C

// ==========================================================================
// fields
`define SCS_CTRL_FAST_BIT  0
`define SCS_CTRL_LP_BIT    1
`define SCS_CTRL_RST       2'h0
`define SCS_ST_BUSY_BIT    0
`define SCS_ST_STALE_BIT   1
`define SCS_ST_SAVE_BIT    2
`define SCS_ST_MODE_LSB    3

// ==========================================================================
// coding
`define SCS_RES_BITS       16
`define SCS_MSB_CODE       16'h8000
`define SCS_ZERO_CODE      16'h0000

// ==========================================================================
// bus answers
`define SCS_RESP_OKAY      2'h0
`define SCS_RESP_SLVERR    2'h2

// ==========================================================================
// timing: 40 MHz system clock
`define SCS_CLK_MHZ        40
`define SCS_IDLE_MS        1
`define SCS_IDLE_CYC       (`SCS_IDLE_MS * 1000 * `SCS_CLK_MHZ)
`define SCS_STEP_FAST      4'h2
`define SCS_STEP_NORMAL    4'h3
`define SCS_STEP_LOWPWR    4'h3

`endif

// ==== include/scs_pkg.sv ====
// types of the conversion sequencer
// assumes nothing beyond a SystemVerilog compiler
package scs_pkg;

    typedef enum logic [1:0] {
        SCS_MODE_NORMAL = 2'h0,
        SCS_MODE_FAST   = 2'h1,
        SCS_MODE_LOWPWR = 2'h2
    } scs_mode_t;

    // gray along track -> convert -> finish
    typedef enum logic [1:0] {
        SCS_ST_TRACK   = 2'h0,
        SCS_ST_CONVERT = 2'h1,
        SCS_ST_FINISH  = 2'h3
    } scs_state_t;

endpackage : scs_pkg

// ==== include/scs_sar_if.sv ====
// carrier between the sequencer control and the approximation engine
// assumes one clock shared by both ends
`timescale 1ns/10ps

interface scs_sar_if;
    logic        start;
    logic        step;
    logic        cmp_high;
    logic [15:0] trial;
    logic        done;
    logic [15:0] code;

    modport ctrl   (output start, output step, output cmp_high,
                    input trial, input done, input code);
    modport engine (input start, input step, input cmp_high,
                    output trial, output done, output code);
endinterface : scs_sar_if

// ==== core/scs_sar_engine.sv ====
// successive-approximation engine: one bit trial per step pulse
// assumes cmp_high is the comparator answer for the trial now on the array
`timescale 1ns/10ps
`include "scs_consts.svh"

module scs_sar_engine #(
    parameter int BITS = `SCS_RES_BITS
) (
    // clock and reset
    input  wire logic   clk_sys_i,
    input  wire logic   rstn_i,
    // towards control
    scs_sar_if.engine   sar
);
    logic [BITS-1:0]    trial_q;
    logic [3:0]         idx_q;
    logic               done_q;
    logic [BITS-1:0]    code_q;

    // ======================================================================
    // bit trials, msb first, weights halving down to one lsb
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            trial_q <= `SCS_ZERO_CODE;
            idx_q   <= 4'hF;
        end else if (sar.start) begin
            trial_q <= `SCS_MSB_CODE;
            idx_q   <= 4'hF;
        end else if (sar.step) begin
            // keep the bit only while the held sample stays at or above it
            if (!sar.cmp_high) begin
                trial_q[idx_q] <= 1'b0;
            end
            if (idx_q != 4'h0) begin
                trial_q[idx_q - 4'h1] <= 1'b1;
                idx_q <= idx_q - 4'h1;
            end
        end
    end

    // ======================================================================
    // result word; over- and under-range fall out as all ones / all zeros
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            done_q <= 1'b0;
            code_q <= `SCS_ZERO_CODE;
        end else begin
            done_q <= sar.step && idx_q == 4'h0;
            if (sar.step && idx_q == 4'h0) begin
                code_q <= sar.cmp_high ? trial_q : (trial_q & ~BITS'(1));
            end
        end
    end

    assign sar.trial = trial_q;
    assign sar.done  = done_q;
    assign sar.code  = code_q;

endmodule : scs_sar_engine

// ==== core/scs_sequencer.sv ====
// conversion sequencer of a 16-bit successive-approximation converter
// assumes synchronous pins, an analog comparator answering within one cycle,
// and an AXI4-Lite master with at most one write and one read under way
//
// Notes on behaviour
// - track input while no conversion runs
// - input and ground sense sampled together
// - start falling edge begins conversion, ends acquisition
// - array disconnected from inputs at conversion start
// - sixteen bits resolved msb first, binary weights
// - on completion form code, drop busy
// - result ready at end of same conversion
// - exactly three modes: fast, normal, low power
// - fast mode accuracy needs gaps under 1 ms
// - normal mode has no interval restriction
// - low power mode saves power between conversions
// - coding select picks binary or twos complement
// - fixed codes for zero, midscale, full scale
// - over-range clamps to full-scale code
// - under-range clamps to minimum code
// - running conversion never restarted or aborted
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "scs_consts.svh"

module scs_sequencer #(
    parameter int IDLE_CYC = `SCS_IDLE_CYC,
    parameter int BITS     = `SCS_RES_BITS
) (
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rstn_i,
    // conversion pins
    input  wire logic              conversion_start_n_i,
    input  wire logic              output_coding_select_i,
    input  wire logic              power_down_input_i,
    input  wire logic              comparator_high_i,
    output logic                   busy_o,
    output logic [BITS-1:0]        result_o,
    output logic                   result_stale_o,
    // analog switch controls
    output logic                   sample_track_o,
    output logic [BITS-1:0]        dac_trial_o,
    output logic                   power_save_o,
    // axi4-lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    scs_sar_if sar ();

    scs_pkg::scs_state_t    state_q;
    scs_pkg::scs_mode_t     mode_q;
    logic [1:0]             ctrl_q;
    logic                   start_n_q;
    logic                   start_fall;
    logic [3:0]             div_q;
    logic                   step_q;
    logic                   start_q;
    logic [31:0]            idle_q;
    logic                   idle_long_q;
    logic                   stale_q;
    logic [BITS-1:0]        result_q;
    logic [31:0]            count_q;
    logic                   busy_q;
    logic                   save_q;

    // ======================================================================
    // helpers
    // fast bit wins; low power only when fast is low
    function automatic scs_pkg::scs_mode_t mode_of(input logic [1:0] c);
        if (c[`SCS_CTRL_FAST_BIT]) begin
            return scs_pkg::SCS_MODE_FAST;
        end else if (c[`SCS_CTRL_LP_BIT]) begin
            return scs_pkg::SCS_MODE_LOWPWR;
        end
        return scs_pkg::SCS_MODE_NORMAL;
    endfunction : mode_of

    function automatic logic [3:0] step_cyc(input scs_pkg::scs_mode_t m);
        unique case (m)
            scs_pkg::SCS_MODE_FAST:   return `SCS_STEP_FAST;
            scs_pkg::SCS_MODE_LOWPWR: return `SCS_STEP_LOWPWR;
            default:                  return `SCS_STEP_NORMAL;
        endcase
    endfunction : step_cyc

    // ======================================================================
    // start edge
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            start_n_q <= 1'b1;
        end else begin
            start_n_q <= conversion_start_n_i;
        end
    end

    // power-down blocks new starts; a running conversion still completes
    assign start_fall = start_n_q && !conversion_start_n_i && !power_down_input_i;

    // ======================================================================
    // sequence
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            state_q <= scs_pkg::SCS_ST_TRACK;
            start_q <= 1'b0;
            mode_q  <= scs_pkg::SCS_MODE_NORMAL;
        end else begin
            start_q <= 1'b0;
            unique case (state_q)
                scs_pkg::SCS_ST_TRACK: begin
                    if (start_fall) begin
                        state_q <= scs_pkg::SCS_ST_CONVERT;
                        start_q <= 1'b1;
                        mode_q  <= mode_of(ctrl_q);
                    end
                end
                scs_pkg::SCS_ST_CONVERT: begin
                    // further edges and power-down are ignored here
                    if (sar.done) begin
                        state_q <= scs_pkg::SCS_ST_FINISH;
                    end
                end
                scs_pkg::SCS_ST_FINISH: begin
                    state_q <= scs_pkg::SCS_ST_TRACK;
                end
            endcase
        end
    end

    // ======================================================================
    // bit clock: one step pulse per divider wrap
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            div_q  <= 4'h0;
            step_q <= 1'b0;
        end else if (state_q != scs_pkg::SCS_ST_CONVERT || start_q || sar.done) begin
            div_q  <= 4'h0;
            step_q <= 1'b0;
        end else if (div_q == step_cyc(mode_q) - 4'h1) begin
            div_q  <= 4'h0;
            step_q <= 1'b1;
        end else begin
            div_q  <= div_q + 4'h1;
            step_q <= 1'b0;
        end
    end

    assign sar.start    = start_q;
    assign sar.step     = step_q;
    assign sar.cmp_high = comparator_high_i;

    scs_sar_engine #(
        .BITS (BITS)
    ) u_engine (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .sar       (sar)
    );

    // ======================================================================
    // switches: one control for array and dummy keeps both edges aligned
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            sample_track_o <= 1'b1;
        end else if (start_fall && state_q == scs_pkg::SCS_ST_TRACK) begin
            sample_track_o <= 1'b0;
        end else if (sar.done) begin
            sample_track_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            dac_trial_o <= `SCS_ZERO_CODE;
        end else begin
            dac_trial_o <= sar.trial;
        end
    end

    // ======================================================================
    // busy and result
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            busy_q <= 1'b0;
        end else if (start_fall && state_q == scs_pkg::SCS_ST_TRACK) begin
            busy_q <= 1'b1;
        end else if (sar.done) begin
            busy_q <= 1'b0;
        end
    end

    // twos complement differs only by msb; no extra pipeline stage
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            result_q <= `SCS_ZERO_CODE;
            count_q  <= 32'h0;
        end else if (sar.done) begin
            result_q <= output_coding_select_i ? sar.code
                        : (sar.code ^ `SCS_MSB_CODE);
            count_q  <= count_q + 32'h1;
        end
    end

    assign busy_o   = busy_q;
    assign result_o = result_q;

    // ======================================================================
    // idle watch: full accuracy in fast mode needs recent conversions
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            idle_q      <= 32'h0;
            idle_long_q <= 1'b1;
        end else if (start_q) begin
            idle_q      <= 32'h0;
            idle_long_q <= 1'b0;
        end else if (idle_q >= 32'(IDLE_CYC)) begin
            idle_long_q <= 1'b1;
        end else begin
            idle_q      <= idle_q + 32'h1;
        end
    end

    // flag lets the host drop the first result after a long pause
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            stale_q <= 1'b0;
        end else if (start_fall && state_q == scs_pkg::SCS_ST_TRACK) begin
            stale_q <= idle_long_q && mode_of(ctrl_q) == scs_pkg::SCS_MODE_FAST;
        end
    end

    assign result_stale_o = stale_q;

    // ======================================================================
    // power saving between conversions
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            save_q <= 1'b0;
        end else begin
            save_q <= state_q == scs_pkg::SCS_ST_TRACK && !start_fall
                      && (mode_of(ctrl_q) == scs_pkg::SCS_MODE_LOWPWR
                          || power_down_input_i);
        end
    end

    assign power_save_o = save_q;

    // ======================================================================
    // axi4-lite write channel
    logic       aw_hold_q;
    logic       w_hold_q;
    logic [7:0] awaddr_q;
    logic [1:0] wdata_q;
    logic       wlane_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            w_hold_q <= 1'b0;
            wdata_q  <= 2'h0;
            wlane_q  <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata[1:0];
            wlane_q  <= s_axi_wstrb[0];
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_hold_q <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_hold_q;
    assign s_axi_wready  = !w_hold_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SCS_RESP_OKAY;
            ctrl_q       <= `SCS_CTRL_RST;
        end else if (s_axi_bvalid) begin
            if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end else if (aw_hold_q && w_hold_q) begin
            s_axi_bvalid <= 1'b1;
            if (awaddr_q == `SCS_ADDR_CTRL) begin
                s_axi_bresp <= `SCS_RESP_OKAY;
                if (wlane_q) begin
                    ctrl_q <= wdata_q;
                end
            end else if (awaddr_q == `SCS_ADDR_STATUS || awaddr_q == `SCS_ADDR_RESULT
                         || awaddr_q == `SCS_ADDR_COUNT) begin
                s_axi_bresp <= `SCS_RESP_OKAY;
            end else begin
                s_axi_bresp <= `SCS_RESP_SLVERR;
            end
        end
    end

    // ======================================================================
    // axi4-lite read channel
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `SCS_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `SCS_RESP_OKAY;
            unique case (s_axi_araddr)
                `SCS_ADDR_CTRL:   s_axi_rdata <= {30'h0, ctrl_q};
                `SCS_ADDR_STATUS: s_axi_rdata <= {27'h0, mode_q, save_q, stale_q, busy_q};
                `SCS_ADDR_RESULT: s_axi_rdata <= {16'h0, result_q};
                `SCS_ADDR_COUNT:  s_axi_rdata <= count_q;
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `SCS_RESP_SLVERR;
                end
            endcase
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

endmodule : scs_sequencer

// ==== verification/scs_cmp_model.sv ====
// analog front end stand-in: sampling array, hold switches and comparator
// assumes level_i is input minus ground sense in lsb units
`timescale 1ns/10ps

module scs_cmp_model (
    // clock
    input  wire logic               clk_sys_i,
    // from the sequencer
    input  wire logic               sample_track_i,
    input  wire logic [15:0]        dac_trial_i,
    // analog side
    input  wire logic signed [17:0] level_i,
    output logic                    cmp_high_o
);
    logic signed [17:0] held_q;

    // ==========================================================================
    // hold: difference follows the input only while switches are closed
    always_ff @(posedge clk_sys_i) begin
        if (sample_track_i) begin
            held_q <= level_i;
        end
    end

    assign cmp_high_o = held_q >= $signed({2'h0, dac_trial_i});
endmodule : scs_cmp_model

// ==== verification/scs_sequencer_props.sv ====
// concurrent checks on the sequencer pins and bus answers
// assumes it is bound to scs_sequencer and sees only its ports
`timescale 1ns/10ps

module scs_sequencer_props #(
    parameter int BITS = 16
) (
    // clock and reset
    input logic            clk_sys_i,
    input logic            rstn_i,
    // conversion pins
    input logic            conversion_start_n_i,
    input logic            power_down_input_i,
    input logic            busy_o,
    input logic [BITS-1:0] result_o,
    input logic            result_stale_o,
    input logic            sample_track_o,
    input logic [BITS-1:0] dac_trial_o,
    input logic            power_save_o,
    // bus answers
    input logic            s_axi_bvalid,
    input logic            s_axi_bready,
    input logic            s_axi_rvalid,
    input logic            s_axi_rready
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // ==========================================================================
    // busy length counter, too long for a repetition
    logic [7:0] busy_cnt_q;
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || !busy_o) begin
            busy_cnt_q <= 8'h00;
        end else begin
            busy_cnt_q <= busy_cnt_q + 8'h01;
        end
    end

    // ==========================================================================
    // assertions
    property p_start_taken;
        $fell(conversion_start_n_i) && !busy_o && !$past(busy_o) && !power_down_input_i
            |=> busy_o;
    endproperty
    a_start_taken: assert property (p_start_taken) else $error("start edge ignored");
    property p_busy_len;
        $fell(busy_o) |-> busy_cnt_q == 8'h23 || busy_cnt_q == 8'h33;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_busy_min;
        $rose(busy_o) |-> busy_o [*8];
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("conversion cut short");
    property p_track;
        sample_track_o == !busy_o;
    endproperty
    a_track: assert property (p_track) else $error("track switch wrong");
    property p_result_hold;
        $changed(result_o) |-> $fell(busy_o);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved");
    property p_msb_first;
        $rose(busy_o) |=> ##1 dac_trial_o == 16'h8000;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first trial not msb");
    property p_stale_at_start;
        $changed(result_stale_o) |-> $rose(busy_o);
    endproperty
    a_stale_at_start: assert property (p_stale_at_start) else $error("stale moved");
    property p_save_busy;
        busy_o && $past(busy_o) |-> !power_save_o;
    endproperty
    a_save_busy: assert property (p_save_busy) else $error("saving while busy");
    property p_save_pd;
        (power_down_input_i && !busy_o) [*3] |-> power_save_o;
    endproperty
    a_save_pd: assert property (p_save_pd) else $error("no save in power down");
    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_once: assert property (p_b_once) else $error("write answer repeated");
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_once: assert property (p_r_once) else $error("read answer repeated");
endmodule : scs_sequencer_props

bind scs_sequencer scs_sequencer_props #(.BITS(BITS)) u_props (.*);

// ==== verification/tb.sv ====
// self-checking bench for the conversion sequencer
// assumes the comparator stand-in and the bound checker
`timescale 1ns/10ps
`include "scs_consts.svh"

module tb;
    localparam int IDLE = 50;
    logic               clk_sys_i = 1'b0;
    logic               rstn_i = 1'b0;
    logic               start_n = 1'b1, coding = 1'b1, pd = 1'b0, cmp;
    logic signed [17:0] level = 18'sh00000;
    logic               busy, stale, track, psave;
    logic [15:0]        result, trial, last_code;
    logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
    logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic               arvalid = 1'b0, rready = 1'b0;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [31:0]        wdata = 32'h0, rdata;
    logic [1:0]         bresp, rresp;
    int                 err_count = 0, num_checks = 0, n_conv = 0;

    scs_sequencer #(.IDLE_CYC(IDLE)) uut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .conversion_start_n_i(start_n),
        .output_coding_select_i(coding), .power_down_input_i(pd),
        .comparator_high_i(cmp), .busy_o(busy), .result_o(result),
        .result_stale_o(stale), .sample_track_o(track), .dac_trial_o(trial),
        .power_save_o(psave), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    scs_cmp_model u_front (.clk_sys_i(clk_sys_i), .sample_track_i(track),
        .dac_trial_i(trial), .level_i(level), .cmp_high_o(cmp));

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // ==========================================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string msg);
        num_checks++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected at %0t: %s seen %h want %h", $time, msg, seen, want);
        end
    endtask : check

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_sys_i);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        check(bresp, r, "write resp");
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_sys_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        check(rdata, d, "read data");
        check(rresp, r, "read resp");
    endtask : axi_rd

    // one conversion; poke disturbs pins while busy
    task automatic conv(input logic signed [17:0] lv, input logic sb, input int cyc,
                        input logic st, input logic poke);
        int          n;
        logic [15:0] code;
        code = (lv > 18'sh0FFFF) ? 16'hFFFF : (lv < 0) ? 16'h0000 : lv[15:0];
        if (!sb) code = code ^ 16'h8000;
        level  <= lv;
        coding <= sb;
        @(posedge clk_sys_i);
        start_n <= 1'b0;
        @(posedge clk_sys_i);
        start_n <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (poke) start_n <= n[0] || n >= 20;
            pd <= poke && n < 20;
            if (poke) level <= -18'sh00005;
        end while (busy !== 1'b0 && n < 200);
        n_conv++;
        last_code = code;
        check(n - 1, cyc, "busy length");
        check(result, code, "result code");
        check(stale, st, "stale flag");
    endtask : conv

    // ==========================================================================
    // scenarios
    task automatic t_reset;
        check({busy, track, psave, stale}, 4'h4, "reset pins");
        check(result, 16'h0000, "reset result");
        axi_rd(`SCS_ADDR_CTRL, 32'h0, `SCS_RESP_OKAY);
        axi_rd(`SCS_ADDR_COUNT, 32'h0, `SCS_RESP_OKAY);
    endtask : t_reset

    task automatic t_fast;
        axi_wr(`SCS_ADDR_CTRL, 32'h1, `SCS_RESP_OKAY);
        conv(18'sh01234, 1'b1, 35, 1'b1, 1'b0);
        conv(18'sh0F00D, 1'b0, 35, 1'b0, 1'b0);
        repeat (IDLE + 10) @(posedge clk_sys_i);
        conv(18'sh0C0DE, 1'b1, 35, 1'b1, 1'b0);
    endtask : t_fast

    task automatic t_codes;
        logic signed [17:0] lv [8] = '{18'sh00000, 18'sh08000, 18'sh0FFFF, 18'sh08001,
                                       18'sh00001, 18'sh07FFF, 18'sh10064, -18'sh00003};
        axi_wr(`SCS_ADDR_CTRL, 32'h0, `SCS_RESP_OKAY);
        foreach (lv[i]) begin
            conv(lv[i], 1'b1, 51, 1'b0, 1'b0);
            conv(lv[i], 1'b0, 51, 1'b0, 1'b0);
        end
        repeat (IDLE + 10) @(posedge clk_sys_i);
        conv(18'sh0ABCD, 1'b1, 51, 1'b0, 1'b0);
    endtask : t_codes

    task automatic t_lowpower;
        axi_wr(`SCS_ADDR_CTRL, 32'h2, `SCS_RESP_OKAY);
        repeat (2) @(posedge clk_sys_i);
        check(psave, 1'b1, "lp save");
        conv(18'sh05555, 1'b1, 51, 1'b0, 1'b1);
        axi_wr(`SCS_ADDR_CTRL, 32'h0, `SCS_RESP_OKAY);
        repeat (2) @(posedge clk_sys_i);
        check(psave, 1'b0, "normal no save");
        pd <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        check(psave, 1'b1, "pd save");
        start_n <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        check(busy, 1'b0, "pd blocks start");
        pd      <= 1'b0;
        start_n <= 1'b1;
    endtask : t_lowpower

    task automatic t_bus;
        axi_rd(`SCS_ADDR_RESULT, {16'h0, last_code}, `SCS_RESP_OKAY);
        axi_rd(`SCS_ADDR_COUNT, n_conv, `SCS_RESP_OKAY);
        axi_wr(`SCS_ADDR_STATUS, 32'hFFFF_FFFF, `SCS_RESP_OKAY);
        axi_wr(8'h10, 32'h1, `SCS_RESP_SLVERR);
        axi_rd(8'h10, 32'h0, `SCS_RESP_SLVERR);
        axi_rd(`SCS_ADDR_CTRL, 32'h0, `SCS_RESP_OKAY);
    endtask : t_bus

    task automatic tally_and_finish;
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_reset();
        t_fast();
        t_codes();
        t_lowpower();
        t_bus();
        tally_and_finish();
    end

    // runs ~1300 cycles; 20000 means a hang
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        tally_and_finish();
    end
endmodule : tb
